// ===== design/calib_lock_crc_regs.sv
// Register bank for calibration trims, reserved words, write lock and configuration checksum
`timescale 1ns/1ps
`default_nettype none
module calib_lock_crc_regs (
  input wire logic clock,
  input wire logic nrst,
  input wire calib_lock_pkg::reg_req_t req,
  input wire logic [1:0] dev_addr,
  input wire logic modulator_clock,
  output calib_lock_pkg::reg_rsp_t rsp,
  output logic [23:0] offset_trim,
  output logic [23:0] gain_trim,
  output logic map_locked
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [23:0] offset_trim_r;
  logic [23:0] gain_trim_r;
  logic [23:0] rsv_b_r;
  logic [7:0] rsv_c_r;
  logic [7:0] lock_key_r;
  logic [15:0] variant_r;
  logic [15:0] checksum;
  logic [3:0] reg_addr;
  logic addr_hit;
  logic unlocked;
  logic wr_ok;
  logic [23:0] rdata_nxt;
  logic mclk_s1_r;
  logic mclk_s2_r;
  logic mclk_s3_r;
  logic mclk_level_r;
  logic mclk_tick;

  // Decode of the command byte
  function automatic logic dev_match(input logic [7:0] cmd, input logic [1:0] da);
    dev_match = (cmd[calib_lock_pkg::CMD_DEV_HI:calib_lock_pkg::CMD_DEV_LO] == da);
  endfunction

  assign reg_addr = req.cmd[calib_lock_pkg::CMD_REG_HI:calib_lock_pkg::CMD_REG_LO];
  assign addr_hit = req.valid && dev_match(req.cmd, dev_addr);
  assign unlocked = (lock_key_r == calib_lock_pkg::UNLOCK_CODE);
  // Key register always writable, the rest only while unlocked
  assign wr_ok = addr_hit && req.write && (unlocked || reg_addr == calib_lock_pkg::ADDR_LOCK_KEY);

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  // Trim words; reset to zero offset and unity gain
  always_ff @(posedge clock) begin
    if (!nrst) begin
      offset_trim_r <= calib_lock_pkg::RST_OFFSET_TRIM;
      gain_trim_r <= calib_lock_pkg::RST_GAIN_TRIM;
    end else if (wr_ok) begin
      if (reg_addr == calib_lock_pkg::ADDR_OFFSET_TRIM) begin
        offset_trim_r <= req.wdata;
      end
      if (reg_addr == calib_lock_pkg::ADDR_GAIN_TRIM) begin
        gain_trim_r <= req.wdata;
      end
    end
  end

  // Reserved and variant words keep plain storage; host keeps only the two reserved words at reset values
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rsv_b_r <= calib_lock_pkg::RST_RSV_B;
      rsv_c_r <= calib_lock_pkg::RST_RSV_C;
      variant_r <= calib_lock_pkg::RST_VARIANT;
    end else if (wr_ok) begin
      if (reg_addr == calib_lock_pkg::ADDR_RSV_B) begin
        rsv_b_r <= req.wdata;
      end
      if (reg_addr == calib_lock_pkg::ADDR_RSV_C) begin
        rsv_c_r <= req.wdata[7:0];
      end
      if (reg_addr == calib_lock_pkg::ADDR_VARIANT) begin
        variant_r <= req.wdata[15:0];
      end
    end
  end

  // Key register; resets unlocked
  always_ff @(posedge clock) begin
    if (!nrst) begin
      lock_key_r <= calib_lock_pkg::UNLOCK_CODE;
    end else if (wr_ok && reg_addr == calib_lock_pkg::ADDR_LOCK_KEY) begin
      lock_key_r <= req.wdata[7:0];
    end
  end

  // ****************************************************************
  // Modulator clock sampling and checksum
  // ****************************************************************
  // Three stages; the filtered level moves only once stages two and three agree,
  // so a sample caught mid-transition can never make a tick on its own
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mclk_s1_r <= 1'b0;
      mclk_s2_r <= 1'b0;
      mclk_s3_r <= 1'b0;
      mclk_level_r <= 1'b0;
    end else begin
      mclk_s1_r <= modulator_clock;
      mclk_s2_r <= mclk_s1_r;
      mclk_s3_r <= mclk_s2_r;
      if (mclk_s2_r == mclk_s3_r) begin
        mclk_level_r <= mclk_s3_r;
      end
    end
  end
  // Rising edge of the filtered level; a stopped modulator clock gives no ticks
  assign mclk_tick = mclk_s2_r && mclk_s3_r && !mclk_level_r;

  config_crc16 u_crc (
    .clock(clock),
    .nrst(nrst),
    .run(!unlocked),
    .tick(mclk_tick),
    .image({offset_trim_r, gain_trim_r, rsv_b_r, rsv_c_r, lock_key_r, variant_r}),
    .result(checksum)
  );

  // ****************************************************************
  // Read path and outputs
  // ****************************************************************
  // Read mux; addresses outside this bank answer zero with hit low
  always_comb begin
    rdata_nxt = 24'h000000;
    case (reg_addr)
      calib_lock_pkg::ADDR_OFFSET_TRIM: rdata_nxt = offset_trim_r;
      calib_lock_pkg::ADDR_GAIN_TRIM: rdata_nxt = gain_trim_r;
      calib_lock_pkg::ADDR_RSV_B: rdata_nxt = rsv_b_r;
      calib_lock_pkg::ADDR_RSV_C: rdata_nxt = {16'h0000, rsv_c_r};
      calib_lock_pkg::ADDR_LOCK_KEY: rdata_nxt = {16'h0000, lock_key_r};
      calib_lock_pkg::ADDR_VARIANT: rdata_nxt = {8'h00, variant_r};
      calib_lock_pkg::ADDR_CHECKSUM: rdata_nxt = {8'h00, checksum};
      default: rdata_nxt = 24'h000000;
    endcase
  end

  // Answer one cycle after the request; foreign device address gives no answer
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rsp <= '0;
      map_locked <= 1'b0;
    end else begin
      rsp.valid <= addr_hit;
      rsp.hit <= addr_hit && reg_addr >= calib_lock_pkg::ADDR_OFFSET_TRIM;
      rsp.rdata <= addr_hit ? rdata_nxt : 24'h000000;
      map_locked <= !unlocked;
    end
  end

  // Trim outputs registered for the conversion datapath
  always_ff @(posedge clock) begin
    if (!nrst) begin
      offset_trim <= calib_lock_pkg::RST_OFFSET_TRIM;
      gain_trim <= calib_lock_pkg::RST_GAIN_TRIM;
    end else begin
      offset_trim <= offset_trim_r;
      gain_trim <= gain_trim_r;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Reset values, lock behaviour, read path and tick shape
  AST_LOCKED_WRITE_BLOCKED: assert property (@(posedge clock) disable iff (!nrst)
    (addr_hit && req.write && !unlocked && reg_addr != calib_lock_pkg::ADDR_LOCK_KEY)
    |=> $stable(offset_trim_r) && $stable(gain_trim_r) && $stable(rsv_b_r)
    && $stable(rsv_c_r) && $stable(variant_r))
    else $error("register changed by a write while locked");
  AST_UNLOCKED_WRITE_TAKES: assert property (@(posedge clock) disable iff (!nrst)
    (addr_hit && req.write && unlocked && reg_addr == calib_lock_pkg::ADDR_OFFSET_TRIM)
    |=> offset_trim_r == $past(req.wdata))
    else $error("offset trim write lost while unlocked");
  AST_KEY_ALWAYS_WRITABLE: assert property (@(posedge clock) disable iff (!nrst)
    (addr_hit && req.write && reg_addr == calib_lock_pkg::ADDR_LOCK_KEY)
    |=> lock_key_r == $past(req.wdata[7:0]))
    else $error("key write lost");
  AST_UNLOCKED_SUM_ZERO: assert property (@(posedge clock) disable iff (!nrst)
    unlocked |=> checksum == 16'h0000 || !$past(unlocked))
    else $error("checksum nonzero while unlocked");
  AST_FOREIGN_ADDR_SILENT: assert property (@(posedge clock) disable iff (!nrst)
    (req.valid && !dev_match(req.cmd, dev_addr)) |=> !rsp.valid)
    else $error("answered a foreign device address");
  AST_SUM_FROZEN_NO_CLOCK: assert property (@(posedge clock) disable iff (!nrst)
    (!unlocked && $past(!unlocked) && !mclk_tick) |=> $stable(checksum))
    else $error("checksum moved without a modulator tick");
  AST_READ_SUM: assert property (@(posedge clock) disable iff (!nrst)
    (addr_hit && reg_addr == calib_lock_pkg::ADDR_CHECKSUM) |=> rsp.rdata == {8'h00, $past(checksum)})
    else $error("checksum read mismatch");
  AST_GAIN_RESET: assert property (@(posedge clock)
    !nrst |=> gain_trim_r == calib_lock_pkg::RST_GAIN_TRIM)
    else $error("gain trim not at unity after reset");
  AST_OFFSET_RESET: assert property (@(posedge clock)
    !nrst |=> offset_trim_r == calib_lock_pkg::RST_OFFSET_TRIM
    && offset_trim == calib_lock_pkg::RST_OFFSET_TRIM)
    else $error("offset trim not zero after reset");
  AST_RESERVED_RESET: assert property (@(posedge clock)
    !nrst |=> rsv_b_r == calib_lock_pkg::RST_RSV_B && rsv_c_r == calib_lock_pkg::RST_RSV_C
    && variant_r == calib_lock_pkg::RST_VARIANT)
    else $error("reserved words not at their reset values");
  AST_UNMAPPED_NO_HIT: assert property (@(posedge clock) disable iff (!nrst)
    (addr_hit && reg_addr < calib_lock_pkg::ADDR_OFFSET_TRIM)
    |=> rsp.valid && !rsp.hit && rsp.rdata == 24'h000000)
    else $error("address below the bank answered with data");
  AST_LOCK_FLAG: assert property (@(posedge clock) disable iff (!nrst)
    (lock_key_r != calib_lock_pkg::UNLOCK_CODE) |=> map_locked)
    else $error("lock flag low with a foreign key");
  AST_TICK_ONE_CYCLE: assert property (@(posedge clock) disable iff (!nrst)
    mclk_tick |=> !mclk_tick)
    else $error("modulator tick longer than one cycle");
  AST_GAIN_PORT_FOLLOWS: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> gain_trim == $past(gain_trim_r))
    else $error("gain trim port does not follow the register");
  COV_LOCK: cover property (@(posedge clock) disable iff (!nrst) $rose(!unlocked));
  COV_SUM: cover property (@(posedge clock) disable iff (!nrst) $changed(checksum) && checksum != 0);
  COV_BLOCKED: cover property (@(posedge clock) disable iff (!nrst) addr_hit && req.write && !wr_ok);
  COV_UNMAPPED: cover property (@(posedge clock) disable iff (!nrst)
    addr_hit && reg_addr < calib_lock_pkg::ADDR_OFFSET_TRIM);
  COV_FOREIGN: cover property (@(posedge clock) disable iff (!nrst) req.valid && !addr_hit);
endmodule
`default_nettype wire

// ===== design/calib_lock_pkg.sv
// Constants and carrier types for the calibration, lock and checksum register bank
// ****************************************************************
// What this block does
// - Register 0x9 holds a 24-bit signed offset trim word, written MSB first, reset to zero.
// - Register 0xA holds a 24-bit unsigned gain trim word, written MSB first.
// - The gain trim word resets to 800000 hex, which means a gain of exactly 1x.
// - While the key register at 0xD holds 0xA5, its reset value, every register except the read-only checksum at 0xF is writable.
// - With any other key value only the key register itself accepts writes.
// - While unlocked no checksum is computed and the checksum register reads 0x0000.
// - While locked the checksum is recomputed continuously whenever the modulator clock runs.
// - The 16-bit CRC-16 checksum of the configuration reads from read-only register 0xF.
// - Register 0xE is a 16-bit read/write word whose reset value depends on the variant.
// - A command is acted on only when its top two address bits match the device address on the dev_addr strap, 01 by default.
// ****************************************************************
package calib_lock_pkg;
  // Register addresses
  localparam logic [3:0] ADDR_OFFSET_TRIM = 4'h9;
  localparam logic [3:0] ADDR_GAIN_TRIM = 4'ha;
  localparam logic [3:0] ADDR_RSV_B = 4'hb;
  localparam logic [3:0] ADDR_RSV_C = 4'hc;
  localparam logic [3:0] ADDR_LOCK_KEY = 4'hd;
  localparam logic [3:0] ADDR_VARIANT = 4'he;
  localparam logic [3:0] ADDR_CHECKSUM = 4'hf;
  // Reset values
  localparam logic [23:0] RST_OFFSET_TRIM = 24'h000000;
  localparam logic [23:0] RST_GAIN_TRIM = 24'h800000;
  localparam logic [23:0] RST_RSV_B = 24'h900000;
  localparam logic [7:0] RST_RSV_C = 8'h50;
  localparam logic [7:0] UNLOCK_CODE = 8'ha5;
  localparam logic [15:0] RST_VARIANT = 16'h0001; // Arbitrary value
  localparam logic [15:0] RST_CHECKSUM = 16'h0000;
  // Device address and command field positions
  localparam logic [1:0] DEV_ADDR_DEFAULT = 2'h1;
  localparam int CMD_DEV_HI = 7;
  localparam int CMD_DEV_LO = 6;
  localparam int CMD_REG_HI = 5;
  localparam int CMD_REG_LO = 2;
  // CRC-16 generator and stream length
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_SEED = 16'h0000;
  localparam int CRC_STREAM_BITS = 104;
  localparam logic [6:0] CRC_LAST_BIT = 7'd103;

  // One register access taken from the SPI command layer
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] cmd;
    logic [23:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [23:0] rdata;
  } reg_rsp_t;
endpackage

// ===== design/config_crc16.sv
// Serial CRC-16 engine that walks the configuration image one bit per modulator tick
`timescale 1ns/1ps
`default_nettype none
module config_crc16 (
  input wire logic clock,
  input wire logic nrst,
  input wire logic run,
  input wire logic tick,
  input wire logic [103:0] image,
  output logic [15:0] result
);
  typedef enum logic [1:0] {
    CRC_IDLE = 2'b01,
    CRC_SHIFT = 2'b10
  } crc_state_t;

  crc_state_t state_r;
  logic [6:0] bit_r;
  logic [15:0] acc_r;
  logic in_bit;
  logic fb;

  // Feedback of the MSB-first shift register
  assign in_bit = image[7'(calib_lock_pkg::CRC_LAST_BIT - bit_r)];
  assign fb = in_bit ^ acc_r[15];

  // Pass sequencer; only advances on a modulator tick while locked
  always_ff @(posedge clock) begin
    if (!nrst || !run) begin
      state_r <= CRC_IDLE;
      bit_r <= 7'd0;
      acc_r <= calib_lock_pkg::CRC_SEED;
    end else if (tick) begin
      case (state_r)
        CRC_IDLE: begin
          state_r <= CRC_SHIFT;
          bit_r <= 7'd0;
          acc_r <= calib_lock_pkg::CRC_SEED;
        end
        CRC_SHIFT: begin
          acc_r <= {acc_r[14:0], 1'b0} ^ (fb ? calib_lock_pkg::CRC_POLY : 16'h0000);
          if (bit_r == calib_lock_pkg::CRC_LAST_BIT) begin
            state_r <= CRC_IDLE;
          end else begin
            bit_r <= bit_r + 7'd1;
          end
        end
        default: state_r <= CRC_IDLE;
      endcase
    end
  end

  // Publish only finished passes so a read never sees a half sum; cleared when unlocked
  always_ff @(posedge clock) begin
    if (!nrst || !run) begin
      result <= calib_lock_pkg::RST_CHECKSUM;
    end else if (tick && state_r == CRC_SHIFT && bit_r == calib_lock_pkg::CRC_LAST_BIT) begin
      result <= {acc_r[14:0], 1'b0} ^ (fb ? calib_lock_pkg::CRC_POLY : 16'h0000);
    end
  end
endmodule
`default_nettype wire

// ===== test/host_model.sv
// Host-side command model that issues single register accesses to the bank
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clock,
  input wire calib_lock_pkg::reg_rsp_t rsp,
  output var calib_lock_pkg::reg_req_t req
);
  // ****************************************************************
  // Idle bus at time zero
  // ****************************************************************
  initial begin
    req = '0;
  end

  // One access: request held for one edge, answer taken a cycle later
  task automatic access(input logic wr, input logic [7:0] cmd, input logic [23:0] wd,
                        output calib_lock_pkg::reg_rsp_t seen);
    @(negedge clock);
    req.valid = 1'b1;
    req.write = wr;
    req.cmd = cmd; // Caller puts the device address, matching or foreign, on top
    req.wdata = wd;
    @(negedge clock);
    seen = rsp;
    // Released lines show inverted junk so stale data cannot pass as valid
    req.valid = 1'b0;
    req.write = ~wr;
    req.cmd = ~cmd;
    req.wdata = ~wd;
  endtask
endmodule
`default_nettype wire

// ===== test/calib_lock_crc_regs_tb.sv
// Self-checking bench for the calibration, lock and checksum register bank
`timescale 1ns/1ps
`default_nettype none
module calib_lock_crc_regs_tb;
  // ****************************************************************
  // Signals, design and host model
  // ****************************************************************
  logic clock;
  logic nrst;
  logic [1:0] dev_addr;
  logic modulator_clock;
  logic mclk_run;
  logic [23:0] offset_trim;
  logic [23:0] gain_trim;
  logic map_locked;
  calib_lock_pkg::reg_req_t req;
  calib_lock_pkg::reg_rsp_t rsp;
  calib_lock_pkg::reg_rsp_t seen;
  int error_cnt;
  int checks;
  typedef struct packed {
    logic wr;
    logic [7:0] cmd;
    logic [23:0] wd;
    logic [1:0] vh;
    logic [23:0] rd;
  } row_t;
  // Reset reads, unmapped and foreign reads, then write/readback pairs
  localparam row_t ROWS [0:16] = '{
    '{1'b0, 8'h64, 24'h0, 2'h3, 24'h000000}, '{1'b0, 8'h68, 24'h0, 2'h3, 24'h800000},
    '{1'b0, 8'h6c, 24'h0, 2'h3, 24'h900000}, '{1'b0, 8'h70, 24'h0, 2'h3, 24'h000050},
    '{1'b0, 8'h74, 24'h0, 2'h3, 24'h0000a5}, '{1'b0, 8'h78, 24'h0, 2'h3, 24'h000001},
    '{1'b0, 8'h7c, 24'h0, 2'h3, 24'h000000}, '{1'b0, 8'h4c, 24'h0, 2'h2, 24'h000000},
    '{1'b0, 8'ha4, 24'h0, 2'h0, 24'h000000}, '{1'b1, 8'h64, 24'hfedcba, 2'h3, 24'h0},
    '{1'b0, 8'h64, 24'h0, 2'h3, 24'hfedcba}, '{1'b1, 8'h68, 24'h7fffff, 2'h3, 24'h0},
    '{1'b0, 8'h68, 24'h0, 2'h3, 24'h7fffff}, '{1'b1, 8'h78, 24'h00beef, 2'h3, 24'h0},
    '{1'b0, 8'h78, 24'h0, 2'h3, 24'h00beef}, '{1'b1, 8'h7c, 24'h001234, 2'h3, 24'h0},
    '{1'b0, 8'h7c, 24'h0, 2'h3, 24'h000000}};

  calib_lock_crc_regs calib_lock_crc_regs_i (.clock(clock), .nrst(nrst), .req(req),
    .dev_addr(dev_addr), .modulator_clock(modulator_clock), .rsp(rsp),
    .offset_trim(offset_trim), .gain_trim(gain_trim), .map_locked(map_locked));
  host_model host_model_i (.clock(clock), .rsp(rsp), .req(req));

  // ****************************************************************
  // Clocks and watchdog
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Modulator clock stands still while not running, 8 system clocks a period
  initial begin
    modulator_clock = 1'b0;
    forever begin
      #40;
      if (mclk_run) modulator_clock = ~modulator_clock;
    end
  end
  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    close_out();
  end

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic check(input string what, input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [23:0] exp);
    host_model_i.access(1'b0, cmd, 24'h0, seen);
    check("read data", seen.rdata, exp);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [23:0] wd);
    host_model_i.access(1'b1, cmd, wd, seen);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Independent MSB-first CRC-16, poly 0x8005, zero seed
  function automatic logic [15:0] crc_of(input logic [103:0] img);
    logic [15:0] c;
    logic fb;
    c = 16'h0000;
    for (int i = 103; i >= 0; i--) begin
      fb = c[15] ^ img[i];
      c = {c[14:0], 1'b0};
      if (fb) c = c ^ 16'h8005;
    end
    return c;
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    dev_addr = 2'h1;
    mclk_run = 1'b0;
    error_cnt = 0;
    checks = 0;
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    foreach (ROWS[i]) begin
      host_model_i.access(ROWS[i].wr, ROWS[i].cmd, ROWS[i].wd, seen);
      check("valid hit", {22'h0, seen.valid, seen.hit}, {22'h0, ROWS[i].vh});
      if (!ROWS[i].wr) check("row read", seen.rdata, ROWS[i].rd);
    end
    check("offset port", offset_trim, 24'hfedcba);
    check("gain port", gain_trim, 24'h7fffff);
    wr(8'h6c, 24'h900000);
    wr(8'h70, 24'h000050);
    $display("table test done");
    // Lock with a non-unlock key, then change the key while locked
    wr(8'h74, 24'h000000);
    wr(8'h74, 24'h00003c);
    rd(8'h74, 24'h00003c);
    check("locked flag", {23'h0, map_locked}, 24'h1);
    wr(8'h64, 24'h111111);
    rd(8'h64, 24'hfedcba);
    wr(8'h68, 24'h123456);
    rd(8'h68, 24'h7fffff);
    check("offset port locked", offset_trim, 24'hfedcba);
    repeat (1200) @(negedge clock);
    rd(8'h7c, 24'h000000);
    mclk_run = 1'b1;
    repeat (1200) @(negedge clock);
    rd(8'h7c, {8'h0, crc_of({24'hfedcba, 24'h7fffff, 24'h900000, 8'h50, 8'h3c,
      16'hbeef})});
    $display("lock test done");
    // Unlock clears the sum and reopens the map
    wr(8'h74, 24'h0000a5);
    rd(8'h7c, 24'h000000);
    check("unlocked flag", {23'h0, map_locked}, 24'h0);
    wr(8'h64, 24'h000001);
    rd(8'h64, 24'h000001);
    // A different strap moves the device address
    dev_addr = 2'h2;
    rd(8'ha8, 24'h7fffff);
    host_model_i.access(1'b0, 8'h68, 24'h0, seen);
    check("foreign valid", {23'h0, seen.valid}, 24'h0);
    dev_addr = 2'h1;
    // Reset in mid-run restores the trims
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    rd(8'h64, 24'h000000);
    check("gain port reset", gain_trim, 24'h800000);
    $display("strap and reset test done");
    close_out();
  end
endmodule
`default_nettype wire
